// ==== include/ppf_cfg.svh ====
// Register offsets, field positions, reset values and pin masks of the port block
`ifndef PPF_CFG_SVH
`define PPF_CFG_SVH

// Port indices inside the pin arrays
`define PPF_P0           3'd0
`define PPF_P1           3'd1
`define PPF_P4           3'd2
`define PPF_P5           3'd3
`define PPF_P6           3'd4
`define PPF_P7           3'd5
`define PPF_P12          3'd6
`define PPF_P13          3'd7

// Byte offsets; per-port registers step by four
`define PPF_OFS_DATA     12'h000
`define PPF_OFS_MODE     12'h020
`define PPF_OFS_PULL     12'h040
`define PPF_OFS_CTRL     12'h060
`define PPF_OFS_RISE     12'h064
`define PPF_OFS_FALL     12'h068
`define PPF_OFS_RTBUF    12'h06C
`define PPF_OFS_STAT     12'h070
`define PPF_OFS_MASK     12'h074

// Control register fields
`define PPF_CTRL_MEM     0
`define PPF_CTRL_ANI     1
`define PPF_CTRL_ANO     2
`define PPF_CTRL_RTP     3
`define PPF_CTRL_FBCUT   4
`define PPF_CTRL_P4IN    5
`define PPF_CTRL_RST     8'h20

// Status fields: bit 0 test flag, bits 7:1 external interrupt pins 0 to 6
`define PPF_STAT_TEST    0
`define PPF_STAT_IRQ_LSB 1

// Reset values
`define PPF_MODE_RST     8'hFF
`define PPF_BYTE_RST     8'h00

// Pin masks
`define PPF_P0_IN_ONLY   8'h81
`define PPF_P7_IMPL      8'h07
`define PPF_P13_IMPL     8'h03
`define PPF_P6_OD        8'h0F

// Control pin positions on the control port
`define PPF_P6_RD        4
`define PPF_P6_WR        5
`define PPF_P6_WAIT      6
`define PPF_P6_ADDRESS_LATCH_STROBE      7

`endif

// ==== include/ppf_pkg.sv ====
// Types shared by the port block
package ppf_pkg;

  typedef logic [7:0]      ppf_byte_t;
  typedef logic [7:0][7:0] ppf_pins_t;

  // External memory cycle sequence
  typedef enum logic [2:0] {
    PPF_BUS_IDLE,
    PPF_BUS_ADDR,
    PPF_BUS_HOLD,
    PPF_BUS_DATA,
    PPF_BUS_DONE
  } ppf_bus_st_t;

endpackage

// ==== hw/ppf_port_ctrl.sv ====
// Port pin function control: direction, pull-ups, alternate functions, AHB-Lite registers
//
// What this block does
// - Most port bits select input or output direction individually.
// - Bus port direction is switched for the whole byte only.
// - Any falling edge on the bus port sets the test flag.
// - Analog input assignment disables pull-ups on that port automatically.
// - Enabled pull-ups apply only while the pin is in input mode.
// - Four control-port pins are open drain, driving only low.
// - One port has only three usable bits, each independently directed.
// - External interrupt pins detect rising, falling or both edges.
// - Real-time outputs update together on a trigger event.
// - In memory expansion mode the bus port carries low address and data.
// - Address latch strobe pulses so external logic captures the address.
// - Control pins used for memory control lose their pull-ups.
`include "ppf_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module ppf_port_ctrl
  import ppf_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Pins
  input  wire ppf_pins_t   pin_in,
  output ppf_pins_t        pin_out,
  output ppf_pins_t        pin_oe,
  output ppf_pins_t        pin_pu,
  // Peripheral side
  input  wire logic        rt_trigger,
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       mem_rdata,
  output logic             mem_done,
  output logic [6:0]       ext_irq_pins,
  output logic             falling_edge_test_flag,
  output logic             feedback_resistor_cut,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  ppf_byte_t   data_r [8];
  ppf_byte_t   mode_r [8];
  ppf_byte_t   pull_r [8];
  ppf_byte_t   ctrl_r;
  logic [6:0]  rise_r;
  logic [6:0]  fall_r;
  ppf_byte_t   rt_buf_r;
  ppf_byte_t   rt_out_r;
  ppf_byte_t   stat_r;
  ppf_byte_t   stat_nxt;
  ppf_byte_t   mask_r;
  logic [63:0] s1_r;
  logic [63:0] s2_r;
  logic [63:0] s3_r;
  logic [63:0] filt_r;
  ppf_pins_t   filt;
  ppf_byte_t   p4_prev_r;
  logic [6:0]  p0_prev_r;
  ppf_bus_st_t bus_st_r;
  ppf_bus_st_t bus_st_nxt;
  logic [15:0] addr_r;
  logic        wr_r;
  ppf_byte_t   wdata_r;
  logic        wr_ph_r;
  logic [11:0] wa_r;
  ppf_byte_t   mode_eff [8];
  ppf_byte_t   rd_val [8];
  logic [31:0] rd_word;
  logic        addr_ok;
  logic        mem_mode;
  logic [7:0]  edge_evt;
  logic        wait_req;

  assign mem_mode = ctrl_r[`PPF_CTRL_MEM];
  assign filt     = ppf_pins_t'(filt_r);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: three stages, change taken when stages two and three agree
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      filt_r <= '0;
    end else if (clk_en) begin
      s1_r   <= 64'(pin_in);
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective direction per bit, 1 means input
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      mode_eff[k] = mode_r[k];
    end
    mode_eff[`PPF_P0]  = mode_r[`PPF_P0] | `PPF_P0_IN_ONLY;
    mode_eff[`PPF_P4]  = {8{ctrl_r[`PPF_CTRL_P4IN]}};
    mode_eff[`PPF_P7]  = mode_r[`PPF_P7] | ~`PPF_P7_IMPL;
    mode_eff[`PPF_P13] = mode_r[`PPF_P13] | ~`PPF_P13_IMPL;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and pull-ups
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      pin_out[k] = data_r[k];
      pin_oe[k]  = ~mode_eff[k];
      pin_pu[k]  = pull_r[k] & mode_eff[k];
    end
    if (ctrl_r[`PPF_CTRL_ANI]) begin
      pin_pu[`PPF_P1] = '0;
    end
    pin_out[`PPF_P6][3:0] = 4'h0;
    pin_oe[`PPF_P6][3:0]  = ~mode_eff[`PPF_P6][3:0] & ~data_r[`PPF_P6][3:0];
    pin_pu[`PPF_P6][3:0]  = 4'h0;
    // real-time outputs come from the trigger-loaded latch
    if (ctrl_r[`PPF_CTRL_RTP]) begin
      pin_out[`PPF_P12] = rt_out_r;
      pin_oe[`PPF_P12]  = 8'hFF;
      pin_pu[`PPF_P12]  = '0;
    end
    // Analog outputs: digital driver and pull-up off
    if (ctrl_r[`PPF_CTRL_ANO]) begin
      pin_oe[`PPF_P13] = '0;
      pin_pu[`PPF_P13] = '0;
    end
    if (mem_mode) begin
      // bus port carries low address then data
      pin_out[`PPF_P4] = (bus_st_r == PPF_BUS_DATA) ? wdata_r : addr_r[7:0];
      pin_oe[`PPF_P4]  = {8{(bus_st_r == PPF_BUS_ADDR) || (bus_st_r == PPF_BUS_HOLD)
                            || ((bus_st_r == PPF_BUS_DATA) && wr_r)}};
      pin_pu[`PPF_P4]  = '0;
      pin_out[`PPF_P5] = addr_r[15:8];
      pin_oe[`PPF_P5]  = 8'hFF;
      pin_pu[`PPF_P5]  = '0;
      // Read and write strobes are active low; wait pin stays an input
      pin_out[`PPF_P6][`PPF_P6_RD]   = ~((bus_st_r == PPF_BUS_DATA) && !wr_r);
      pin_out[`PPF_P6][`PPF_P6_WR]   = ~((bus_st_r == PPF_BUS_DATA) && wr_r);
      pin_oe[`PPF_P6][`PPF_P6_WAIT]  = 1'b0;
      // strobe high only in the address cycle
      pin_out[`PPF_P6][`PPF_P6_ADDRESS_LATCH_STROBE] = (bus_st_r == PPF_BUS_ADDR);
      pin_oe[`PPF_P6][7:4] = 4'b1011;
      pin_pu[`PPF_P6][7:4] = 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read values per port
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      // pin for inputs, latch for outputs
      rd_val[k] = (filt[k] & mode_eff[k]) | (data_r[k] & ~mode_eff[k]);
    end
    // Open-drain pins always read the wire
    rd_val[`PPF_P6][3:0] = filt[`PPF_P6][3:0];
    rd_val[`PPF_P7]  = rd_val[`PPF_P7] & `PPF_P7_IMPL;
    rd_val[`PPF_P13] = rd_val[`PPF_P13] & `PPF_P13_IMPL;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && hready && htrans[1] && (hsize == 3'd2);

  always_comb begin
    rd_word = '0;
    if (haddr < `PPF_OFS_MODE) begin
      rd_word[7:0] = rd_val[haddr[4:2]];
    end else if (haddr < `PPF_OFS_PULL) begin
      rd_word[7:0] = mode_eff[haddr[4:2]];
    end else if (haddr < `PPF_OFS_CTRL) begin
      rd_word[7:0] = pull_r[haddr[4:2]];
    end else begin
      unique case (haddr)
        `PPF_OFS_CTRL:  rd_word[7:0] = ctrl_r;
        `PPF_OFS_RISE:  rd_word[6:0] = rise_r;
        `PPF_OFS_FALL:  rd_word[6:0] = fall_r;
        `PPF_OFS_RTBUF: rd_word[7:0] = rt_buf_r;
        `PPF_OFS_STAT:  rd_word[7:0] = stat_r;
        `PPF_OFS_MASK:  rd_word[7:0] = mask_r;
        default:        rd_word      = '0;
      endcase
    end
  end

  // Read data is captured at the address phase so it stands in the data phase
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hrdata  <= '0;
      wr_ph_r <= 1'b0;
      wa_r    <= '0;
    end else if (clk_en) begin
      wr_ph_r <= addr_ok && hwrite;
      if (addr_ok) begin
        wa_r <= haddr;
      end
      hrdata <= (addr_ok && !hwrite) ? rd_word : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written port registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < 8; k++) begin
        data_r[k] <= `PPF_BYTE_RST;
        mode_r[k] <= `PPF_MODE_RST;
        pull_r[k] <= `PPF_BYTE_RST;
      end
    end else if (clk_en && wr_ph_r) begin
      if (wa_r < `PPF_OFS_MODE) begin
        data_r[wa_r[4:2]] <= hwdata[7:0];
      end else if (wa_r < `PPF_OFS_PULL) begin
        mode_r[wa_r[4:2]] <= hwdata[7:0];
      end else if (wa_r < `PPF_OFS_CTRL) begin
        pull_r[wa_r[4:2]] <= hwdata[7:0];
      end
    end
  end

  // Control, edge selects, real-time buffer, mask
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_r   <= `PPF_CTRL_RST;
      rise_r   <= '0;
      fall_r   <= '0;
      rt_buf_r <= `PPF_BYTE_RST;
      mask_r   <= `PPF_BYTE_RST;
    end else if (clk_en && wr_ph_r) begin
      unique case (wa_r)
        `PPF_OFS_CTRL:  ctrl_r   <= hwdata[7:0];
        `PPF_OFS_RISE:  rise_r   <= hwdata[6:0];
        `PPF_OFS_FALL:  fall_r   <= hwdata[6:0];
        `PPF_OFS_RTBUF: rt_buf_r <= hwdata[7:0];
        `PPF_OFS_MASK:  mask_r   <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // all eight outputs load at once on the trigger
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rt_out_r <= `PPF_BYTE_RST;
    end else if (clk_en && rt_trigger) begin
      rt_out_r <= rt_buf_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on filtered pins
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      p4_prev_r <= '0;
      p0_prev_r <= '0;
    end else if (clk_en) begin
      p4_prev_r <= filt[`PPF_P4];
      p0_prev_r <= filt[`PPF_P0][6:0];
    end
  end

  always_comb begin
    // any falling edge on the bus port
    edge_evt[`PPF_STAT_TEST] = |(p4_prev_r & ~filt[`PPF_P4]);
    // rising, falling or both per pin
    edge_evt[7:1] = (rise_r & ~p0_prev_r & filt[`PPF_P0][6:0])
                  | (fall_r & p0_prev_r & ~filt[`PPF_P0][6:0]);
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_comb begin
    stat_nxt = stat_r;
    if (wr_ph_r && (wa_r == `PPF_OFS_STAT)) begin
      stat_nxt = stat_r & ~hwdata[7:0];
    end
    stat_nxt = stat_nxt | edge_evt;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stat_r <= '0;
    end else if (clk_en) begin
      stat_r <= stat_nxt;
    end
  end

  assign irq                    = |(stat_r & mask_r);
  assign falling_edge_test_flag = stat_r[`PPF_STAT_TEST];
  assign ext_irq_pins           = filt[`PPF_P0][6:0];
  // bit software must set before using the subclock pin
  assign feedback_resistor_cut  = ctrl_r[`PPF_CTRL_FBCUT];

  ////////////////////////////////////////////////////////////////////////////
  // Memory cycle; data phase ends once its strobe is seen low through the pin filter while the wait pin is high
  assign wait_req = ~filt[`PPF_P6][`PPF_P6_WAIT]
                  | (wr_r ? filt[`PPF_P6][`PPF_P6_WR] : filt[`PPF_P6][`PPF_P6_RD]);

  always_comb begin
    bus_st_nxt = bus_st_r;
    unique case (bus_st_r)
      PPF_BUS_IDLE: if (mem_req && mem_mode) bus_st_nxt = PPF_BUS_ADDR;
      PPF_BUS_ADDR: bus_st_nxt = PPF_BUS_HOLD;
      PPF_BUS_HOLD: bus_st_nxt = PPF_BUS_DATA;
      PPF_BUS_DATA: if (!wait_req) bus_st_nxt = PPF_BUS_DONE;
      PPF_BUS_DONE: bus_st_nxt = PPF_BUS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bus_st_r  <= PPF_BUS_IDLE;
      addr_r    <= '0;
      wr_r      <= 1'b0;
      wdata_r   <= '0;
      mem_rdata <= '0;
      mem_done  <= 1'b0;
    end else if (clk_en) begin
      bus_st_r <= bus_st_nxt;
      mem_done <= (bus_st_r == PPF_BUS_DATA) && !wait_req;
      if ((bus_st_r == PPF_BUS_IDLE) && mem_req && mem_mode) begin
        addr_r  <= mem_addr;
        wr_r    <= mem_write;
        wdata_r <= mem_wdata;
      end
      if ((bus_st_r == PPF_BUS_DATA) && !wait_req && !wr_r) begin
        mem_rdata <= filt[`PPF_P4];
      end
    end
  end

endmodule

`default_nettype wire

// ==== tb/ppf_pins_model.sv ====
// External pins and memory model for the port pin function block
`timescale 1ns/10ps
`default_nettype none

module ppf_pins_model
  import ppf_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire ppf_pins_t pin_out,
  input  wire ppf_pins_t pin_oe,
  input  wire ppf_pins_t pin_pu,
  input  wire ppf_pins_t ext_val,
  input  wire ppf_pins_t ext_en,
  input  wire ppf_byte_t mem_val,
  output ppf_pins_t      pin_in
);
  ppf_pins_t  last_r;
  logic [2:0] hold_r = 3'd0;
  logic       rd_act;

  // memory answers while read strobe low
  assign rd_act = pin_oe[4][4] && !pin_out[4][4] && !pin_oe[2][0];

  // Device drive wins; floating lines without pull-up show a changing level
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pin_oe[p][b])
          pin_in[p][b] = pin_out[p][b];
        else if (p == 2 && (rd_act || hold_r != 3'd0))
          pin_in[p][b] = mem_val[b];
        else if (ext_en[p][b])
          pin_in[p][b] = ext_val[p][b];
        else if (pin_pu[p][b])
          pin_in[p][b] = 1'b1;
        else
          pin_in[p][b] = ~last_r[p][b];
      end
    end
  end

  // Short data hold after the strobe, then the bus is released
  always @(posedge sys_clk) begin
    last_r <= pin_in;
    hold_r <= rd_act ? 3'd4 : (hold_r != 3'd0 ? hold_r - 3'd1 : 3'd0);
  end
endmodule

`default_nettype wire

// ==== tb/ppf_port_ctrl_checker.sv ====
// Concurrent assertions on the port pin function block ports
`timescale 1ns/10ps
`default_nettype none

module ppf_port_ctrl_checker
  import ppf_pkg::*;
(
  input wire logic      sys_clk,
  input wire logic      reset,
  input wire ppf_pins_t pin_in,
  input wire ppf_pins_t pin_out,
  input wire ppf_pins_t pin_oe,
  input wire ppf_pins_t pin_pu,
  input wire logic      mem_done,
  input wire logic      falling_edge_test_flag,
  input wire logic      irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Memory cycle steps: strobe up, strobe down, completion
  sequence address_latch_strobe_rise;
    $rose(pin_out[4][7]);
  endsequence
  sequence address_latch_strobe_end;
    !pin_out[4][7] ##[1:20] mem_done;
  endsequence
  // Falling bus port bit well clear of reset, so the synchroniser is primed
  sequence bus_fall;
    !$past(reset, 8) && (($past(pin_in[2]) & ~pin_in[2]) != 8'h00);
  endsequence

  reset_state_a: assert property ($fell(reset) |-> pin_oe == '0 && pin_pu == '0 && !irq)
    else $error("pins not idle after reset");
  pullup_input_a: assert property ((pin_pu & pin_oe) == '0)
    else $error("pull-up on a driven pin");
  open_drain_a: assert property ((pin_out[4][3:0] & pin_oe[4][3:0]) == 4'h0)
    else $error("open drain pin driven high");
  input_only_a: assert property (!pin_oe[0][0] && !pin_oe[0][7])
    else $error("input-only pin driven");
  p7_width_a: assert property (pin_oe[5][7:3] == 5'h00)
    else $error("absent bit of three-bit port driven");
  p13_width_a: assert property (pin_oe[7][7:2] == 6'h00)
    else $error("absent bit of two-bit port driven");
  p4_byte_a: assert property (pin_oe[2] inside {8'h00, 8'hFF})
    else $error("bus port direction split");
  test_flag_a: assert property (bus_fall |-> ##[1:8] falling_edge_test_flag)
    else $error("falling edge did not set test flag");
  address_latch_strobe_cycle_a: assert property (address_latch_strobe_rise |-> ##1 address_latch_strobe_end)
    else $error("strobe not one cycle before completion");
  done_pulse_a: assert property (mem_done |=> !mem_done)
    else $error("done longer than one cycle");
endmodule

bind ppf_port_ctrl ppf_port_ctrl_checker chk_i (
  .sys_clk(sys_clk), .reset(reset), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pu(pin_pu), .mem_done(mem_done), .falling_edge_test_flag(falling_edge_test_flag),
  .irq(irq)
);

`default_nettype wire

// ==== tb/ppf_port_ctrl_test.sv ====
// Self-checking bench for the port pin function block
`include "ppf_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module ppf_port_ctrl_test import ppf_pkg::*;;
  localparam int LIMIT = 20000;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        clk_en = 1'b1;
  logic        hresp;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'd2;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        rt_trigger = 1'b0;
  logic        mem_req = 1'b0;
  logic        mem_write = 1'b0;
  logic [15:0] mem_addr = 16'h0;
  logic [7:0]  mem_wdata = 8'h00;
  logic [7:0]  mem_rdata;
  logic        mem_done;
  logic        fe_flag;
  logic        fb_cut;
  logic        irq;
  logic [6:0]  ext_irq;
  ppf_pins_t   pin_in;
  ppf_pins_t   pin_out;
  ppf_pins_t   pin_oe;
  ppf_pins_t   pin_pu;
  ppf_pins_t   ext_val = '1;
  ppf_byte_t   mem_val = 8'hC3;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [31:0] q;

  ppf_port_ctrl uut (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pu(pin_pu), .rt_trigger(rt_trigger), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_done(mem_done), .ext_irq_pins(ext_irq),
    .falling_edge_test_flag(fe_flag), .feedback_resistor_cut(fb_cut), .irq(irq)
  );
  ppf_pins_model pins (
    .sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu),
    .ext_val(ext_val), .ext_en('1), .mem_val(mem_val), .pin_in(pin_in)
  );

  ////////////////////////////////////////
  // Clock and hang guard
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  function automatic logic [11:0] ra(input logic [11:0] b, input logic [2:0] p);
    return b + {7'h0, p, 2'b00};
  endfunction
  // Single word transfer; waits on hready in both phases
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do tick(1); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do tick(1); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(n, e, q);
  endtask

  ////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    chk("oe", 32'h0, pin_oe[3:0] | pin_oe[7:4]);
    chk("pu", 32'h0, pin_pu[3:0] | pin_pu[7:4]);
    rdc("mode", ra(`PPF_OFS_MODE, `PPF_P1), 32'hFF);
    rdc("ctrl", `PPF_OFS_CTRL, 32'h20);
    rdc("unmapped", 12'h0FC, 32'h0);
    chk("hresp", 32'h0, hresp);
  endtask
  task automatic t_dir;
    wr(ra(`PPF_OFS_MODE, `PPF_P1), 32'hA5);
    wr(ra(`PPF_OFS_DATA, `PPF_P1), 32'h3C);
    wr(ra(`PPF_OFS_PULL, `PPF_P1), 32'hFF);
    ext_val[1] <= 8'h0F;
    tick(6);
    chk("p1 oe", 32'h5A, pin_oe[1]);
    chk("p1 out", 32'h18, pin_out[1] & pin_oe[1]);
    chk("p1 pu", 32'hA5, pin_pu[1]);
    rdc("p1 read", ra(`PPF_OFS_DATA, `PPF_P1), 32'h1D);
  endtask
  task automatic t_limits;
    wr(ra(`PPF_OFS_MODE, `PPF_P0), 32'h0);
    wr(ra(`PPF_OFS_MODE, `PPF_P7), 32'h0);
    wr(ra(`PPF_OFS_MODE, `PPF_P13), 32'h0);
    wr(ra(`PPF_OFS_DATA, `PPF_P13), 32'hFF);
    tick(1);
    chk("p0 oe", 32'h7E, pin_oe[0]);
    chk("p7 oe", 32'h07, pin_oe[5]);
    chk("p13 oe", 32'h03, pin_oe[7]);
    rdc("p7 mode", ra(`PPF_OFS_MODE, `PPF_P7), 32'hF8);
    rdc("p13 read", ra(`PPF_OFS_DATA, `PPF_P13), 32'h03);
  endtask
  task automatic t_od;
    wr(ra(`PPF_OFS_MODE, `PPF_P6), 32'hF0);
    wr(ra(`PPF_OFS_DATA, `PPF_P6), 32'h05);
    tick(6);
    chk("od oe", 32'hA, pin_oe[4][3:0]);
    chk("od out", 32'h0, pin_out[4][3:0]);
    rdc("od read", ra(`PPF_OFS_DATA, `PPF_P6), 32'hF5);
  endtask
  task automatic t_p4;
    wr(ra(`PPF_OFS_MODE, `PPF_P4), 32'h0);
    tick(1);
    chk("p4 bit mode", 32'h0, pin_oe[2]);
    wr(`PPF_OFS_CTRL, 32'h0);
    tick(1);
    chk("p4 out", 32'hFF, pin_oe[2]);
    wr(`PPF_OFS_CTRL, 32'h20);
    tick(1);
    chk("p4 in", 32'h0, pin_oe[2]);
  endtask
  task automatic t_analog;
    wr(ra(`PPF_OFS_MODE, `PPF_P1), 32'hFF);
    tick(1);
    chk("p1 pu in", 32'hFF, pin_pu[1]);
    wr(`PPF_OFS_CTRL, 32'h32);
    tick(1);
    chk("ani pu", 32'h0, pin_pu[1]);
    chk("fb cut", 32'h1, fb_cut);
    wr(`PPF_OFS_CTRL, 32'h20);
  endtask
  task automatic t_flag;
    wr(`PPF_OFS_STAT, 32'hFF);
    tick(1);
    chk("flag idle", 32'h0, fe_flag);
    ext_val[2][3] <= 1'b0;
    tick(8);
    chk("flag set", 32'h1, fe_flag);
    chk("irq masked", 32'h0, irq);
    wr(`PPF_OFS_MASK, 32'h01);
    tick(1);
    chk("irq on", 32'h1, irq);
    rdc("stat", `PPF_OFS_STAT, 32'h01);
    wr(`PPF_OFS_STAT, 32'h01);
    ext_val[2][3] <= 1'b1;
    tick(1);
    chk("irq off", 32'h0, irq);
  endtask
  task automatic t_edges;
    wr(ra(`PPF_OFS_MODE, `PPF_P0), 32'hFF);
    ext_val[0] <= 8'h00;
    tick(6);
    wr(`PPF_OFS_RISE, 32'h05);
    wr(`PPF_OFS_FALL, 32'h06);
    wr(`PPF_OFS_STAT, 32'hFF);
    ext_val[0] <= 8'h07;
    tick(8);
    chk("irq pins", 32'h07, ext_irq);
    rdc("rise stat", `PPF_OFS_STAT, 32'h0A);
    wr(`PPF_OFS_STAT, 32'hFF);
    ext_val[0] <= 8'h00;
    tick(8);
    rdc("fall stat", `PPF_OFS_STAT, 32'h0C);
  endtask
  task automatic t_rtp;
    wr(ra(`PPF_OFS_MODE, `PPF_P12), 32'h0);
    wr(`PPF_OFS_CTRL, 32'h28);
    wr(`PPF_OFS_RTBUF, 32'h96);
    tick(3);
    chk("rt hold", 32'h0, pin_out[6]);
    rt_trigger <= 1'b1;
    tick(1);
    rt_trigger <= 1'b0;
    tick(2);
    chk("rt load", 32'h96, pin_out[6]);
    wr(`PPF_OFS_RTBUF, 32'h5A);
    clk_en <= 1'b0;
    rt_trigger <= 1'b1;
    tick(1);
    clk_en <= 1'b1;
    rt_trigger <= 1'b0;
    tick(2);
    chk("rt frozen", 32'h96, pin_out[6]);
  endtask
  // One external memory cycle; address at the strobe, data at the strobe low
  task automatic mem_op(input logic w, input logic [15:0] a, input ppf_byte_t d);
    int n;
    ppf_byte_t seen;
    mem_write <= w;
    mem_addr <= a;
    mem_wdata <= d;
    mem_req <= 1'b1;
    tick(1);
    mem_req <= 1'b0;
    n = 0;
    while (pin_out[4][7] !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    chk("addr lo", a[7:0], pin_out[2]);
    chk("addr hi", a[15:8], pin_out[3]);
    seen = 8'h00;
    while (mem_done !== 1'b1 && n < 30) begin
      if (pin_oe[4][5] === 1'b1 && pin_out[4][5] === 1'b0) seen = pin_out[2];
      tick(1);
      n++;
    end
    tick(1);
    if (w) chk("wdata", d, seen);
    else chk("rdata", mem_val, mem_rdata);
  endtask
  task automatic t_mem;
    wr(ra(`PPF_OFS_PULL, `PPF_P6), 32'hF0);
    wr(ra(`PPF_OFS_MODE, `PPF_P6), 32'hFF);
    wr(`PPF_OFS_CTRL, 32'h21);
    tick(1);
    chk("ctl pu", 32'h0, pin_pu[4] & 8'hB0);
    mem_op(1'b1, 16'h12AB, 8'h5A);
    mem_op(1'b0, 16'h3456, 8'h00);
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    tick(1);
    t_reset();
    t_dir();
    t_limits();
    t_od();
    t_p4();
    t_analog();
    t_flag();
    t_edges();
    t_rtp();
    t_mem();
    end_sim();
  end
endmodule

`default_nettype wire
